// [nmt_node_pkg.sv]
// Constants shared by the CANopen node network-management controller
package nmt_node_pkg;

  // Message type field of the identifier (upper four bits)
  localparam logic [3:0] MT_NMT    = 4'h0;
  localparam logic [3:0] MT_EMCY   = 4'h1;
  localparam logic [3:0] MT_TPDO1  = 4'h3;
  localparam logic [3:0] MT_RPDO1  = 4'h4;
  localparam logic [3:0] MT_TPDO2  = 4'h5;
  localparam logic [3:0] MT_RPDO2  = 4'h6;
  localparam logic [3:0] MT_SDO_TX = 4'hb;
  localparam logic [3:0] MT_SDO_RX = 4'hc;
  localparam logic [3:0] MT_HB     = 4'he;

  // Network-management command specifiers and broadcast address
  localparam logic [7:0] CMD_OPER      = 8'h01;
  localparam logic [7:0] CMD_STOP      = 8'h02;
  localparam logic [7:0] CMD_PREOP     = 8'h80;
  localparam logic [7:0] CMD_RST_NODE  = 8'h81;
  localparam logic [7:0] CMD_RST_COMM  = 8'h82;
  localparam logic [7:0] NMT_BROADCAST = 8'h00;
  localparam logic [6:0] NMT_ID_NODE   = 7'h00;

  // Heartbeat state codes
  localparam logic [6:0] HB_BOOT  = 7'h00;
  localparam logic [6:0] HB_STOP  = 7'h04;
  localparam logic [6:0] HB_OPER  = 7'h05;
  localparam logic [6:0] HB_PREOP = 7'h7f;

  // Emergency error register byte
  localparam logic [7:0] ERR_SET   = 8'h01;
  localparam logic [7:0] ERR_CLEAR = 8'h00;

  // Selector ranges
  localparam logic [3:0] SEL_NONE      = 4'h0;
  localparam logic [3:0] SEL_DIG_FIRST = 4'h1;
  localparam logic [3:0] SEL_DIG_LAST  = 4'h9;
  localparam logic [3:0] SEL_VIR_FIRST = 4'ha;
  localparam logic [3:0] SEL_ENC1_LAST = 4'hb;
  localparam logic [3:0] SEL_ENC2_LAST = 4'hd;

  // Bit-rate codes: 50k, 100k, 125k, 250k, 500k, 800k, 1M
  localparam logic [2:0] RATE_50K = 3'h0;
  localparam logic [2:0] RATE_1M  = 3'h6;

  // Transmit pending slots, highest priority first
  localparam int P_BOOT  = 0;
  localparam int P_EMCY  = 1;
  localparam int P_TPDO1 = 2;
  localparam int P_TPDO2 = 3;
  localparam int P_HB    = 4;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int HB_PERIOD_MS  = 1000;

  typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_OPER, ST_STOP} nmt_state_e;

endpackage

// [canopen_nmt_node_control.sv]
// Network-management state machine, message gating and node setup of a CANopen slave
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module canopen_nmt_node_control #(
  parameter int CYCLES_PER_MS = nmt_node_pkg::CYCLES_PER_MS,
  parameter int HB_PERIOD_MS  = nmt_node_pkg::HB_PERIOD_MS
) (
  input  wire logic        i_clk,                   // 100 MHz clock
  input  wire logic        i_srst,                  // Synchronous reset, power-on
  input  wire logic        i_startup_done,          // Self-test finished, pulse
  input  wire logic        i_internal_fault,        // Internal fault level
  input  wire logic        i_rx_valid,              // Received frame strobe
  input  wire logic [3:0]  i_rx_type,               // Received message type
  input  wire logic [6:0]  i_rx_node,               // Received identifier node field
  input  wire logic [7:0]  i_rx_data0,              // Received data byte 1
  input  wire logic [7:0]  i_rx_data1,              // Received data byte 2
  input  wire logic        i_tx_ready,              // Frame controller takes frame
  input  wire logic [15:0] i_pdo_timeout_ms,        // PDO gap limit, 0 disables
  input  wire logic [2:0]  i_rate_sel,              // Bit-rate setting
  input  wire logic [6:0]  i_fallback_node_number,  // Node number, input low
  input  wire logic [6:0]  i_alternate_node_number, // Node number, input high
  input  wire logic [3:0]  i_node_number_selector,  // Which input picks the number
  input  wire logic [8:0]  i_dig_in,                // Digital lines, from pins
  input  wire logic [5:0]  i_virt_in,               // Virtual digital inputs
  input  wire logic [8:0]  i_line_is_input,         // Line configured as input
  input  wire logic        i_enc1_en,               // Encoder 1 enabled
  input  wire logic        i_enc2_en,               // Encoder 2 enabled
  output logic             o_init_busy,             // In Initialization
  output logic [6:0]       o_state_code,            // Heartbeat state code
  output logic             o_tx_valid,              // Frame to send
  output logic [3:0]       o_tx_type,               // Message type to send
  output logic [7:0]       o_tx_data0,              // First data byte to send
  output logic             o_pdo_accept,            // Receive PDO taken, pulse
  output logic             o_sdo_accept,            // SDO request taken, pulse
  output logic [6:0]       o_node_number,           // Latched node number
  output logic [2:0]       o_bit_rate,              // Latched bit-rate code
  output logic             o_pdo_timeout_fault,     // PDO gap fault
  output logic             o_selector_conflict_fault // Selector conflict
);

  typedef struct packed {
    nmt_node_pkg::nmt_state_e state;
    logic [6:0]  code;
    logic        init_busy;
    logic [8:0]  s1;
    logic [8:0]  s2;
    logic [8:0]  s3;
    logic [8:0]  filt;
    logic [3:0]  sel;
    logic [6:0]  node;
    logic [2:0]  rate;
    logic        conflict;
    logic [31:0] ms_cnt;
    logic [15:0] hb_cnt;
    logic [15:0] pdo_ms;
    logic        pdo_fault;
    logic [2:0]  err;
    logic [4:0]  pend;
    logic        tx_valid;
    logic [3:0]  tx_type;
    logic [7:0]  tx_d0;
    logic        pdo_acc;
    logic        sdo_acc;
  } node_s;

  node_s st_r;
  node_s st_nxt;
  logic  nmt_hit;
  logic  ms_tick;
  logic  sel_level;
  logic  rx_pdo;
  logic  [2:0] fault_vec;

  // Heartbeat code of a state
  function automatic logic [6:0] code_of(input nmt_node_pkg::nmt_state_e s);
    logic [6:0] c;
    c = nmt_node_pkg::HB_BOOT;
    unique case (s)
      nmt_node_pkg::ST_INIT:  c = nmt_node_pkg::HB_BOOT;
      nmt_node_pkg::ST_PREOP: c = nmt_node_pkg::HB_PREOP;
      nmt_node_pkg::ST_OPER:  c = nmt_node_pkg::HB_OPER;
      nmt_node_pkg::ST_STOP:  c = nmt_node_pkg::HB_STOP;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.pdo_acc = 1'b0;
    st_nxt.sdo_acc = 1'b0;
    sel_level   = 1'b0;
    // Pins pass three flops; a level counts once the last two agree
    st_nxt.s1   = i_dig_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    for (int i = 0; i < $bits(i_dig_in); i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.filt[i] = st_r.s3[i];
    end
    // Millisecond prescaler shared by heartbeat and PDO supervision
    ms_tick       = (st_r.ms_cnt == 32'(CYCLES_PER_MS - 1));
    st_nxt.ms_cnt = ms_tick ? '0 : st_r.ms_cnt + 32'h1;
    rx_pdo = i_rx_valid && (i_rx_type == nmt_node_pkg::MT_RPDO1
                            || i_rx_type == nmt_node_pkg::MT_RPDO2);
    // Only commands addressed to all or to us count, never while booting
    nmt_hit = i_rx_valid && (i_rx_type == nmt_node_pkg::MT_NMT)
              && (i_rx_node == nmt_node_pkg::NMT_ID_NODE)
              && (st_r.state != nmt_node_pkg::ST_INIT)
              && (i_rx_data1 == nmt_node_pkg::NMT_BROADCAST
                  || i_rx_data1 == {1'b0, st_r.node});
    // Level of the input named by the current selector
    if (i_node_number_selector >= nmt_node_pkg::SEL_DIG_FIRST
        && i_node_number_selector <= nmt_node_pkg::SEL_DIG_LAST)
      sel_level = st_r.filt[i_node_number_selector - nmt_node_pkg::SEL_DIG_FIRST];
    else if (i_node_number_selector >= nmt_node_pkg::SEL_VIR_FIRST)
      sel_level = i_virt_in[3'(i_node_number_selector - nmt_node_pkg::SEL_VIR_FIRST)];

    unique case (st_r.state)
      nmt_node_pkg::ST_INIT:
      begin
        // Nothing leaves while booting; settings latch once per entry
        st_nxt.init_busy = 1'b1;
        if (i_startup_done)
        begin
          st_nxt.sel  = i_node_number_selector;
          st_nxt.node = (i_node_number_selector != nmt_node_pkg::SEL_NONE && sel_level)
                        ? i_alternate_node_number
                        : i_fallback_node_number;
          // An out-of-range setting keeps the slowest rate
          st_nxt.rate = (i_rate_sel <= nmt_node_pkg::RATE_1M)
                        ? i_rate_sel : nmt_node_pkg::RATE_50K;
          st_nxt.init_busy = 1'b0;
          st_nxt.state     = nmt_node_pkg::ST_PREOP;
          st_nxt.pend[nmt_node_pkg::P_BOOT] = 1'b1;
          st_nxt.hb_cnt    = '0;
        end
      end
      nmt_node_pkg::ST_PREOP:
      begin
        if (i_rx_valid && i_rx_type == nmt_node_pkg::MT_SDO_RX)
          st_nxt.sdo_acc = 1'b1;
      end
      nmt_node_pkg::ST_OPER:
      begin
        if (i_rx_valid && i_rx_type == nmt_node_pkg::MT_SDO_RX)
          st_nxt.sdo_acc = 1'b1;
        if (rx_pdo)
        begin
          // Each receive PDO is answered by its own transmit PDO
          st_nxt.pdo_acc = 1'b1;
          st_nxt.pdo_ms  = '0;
          if (i_rx_type == nmt_node_pkg::MT_RPDO1)
            st_nxt.pend[nmt_node_pkg::P_TPDO1] = 1'b1;
          else
            st_nxt.pend[nmt_node_pkg::P_TPDO2] = 1'b1;
        end
        else if (ms_tick && st_r.pdo_ms != '1)
          st_nxt.pdo_ms = st_r.pdo_ms + 16'h1;
        if (i_pdo_timeout_ms != '0 && st_r.pdo_ms > i_pdo_timeout_ms)
          st_nxt.pdo_fault = 1'b1;
      end
      nmt_node_pkg::ST_STOP:
      begin
        // PDOs, SDOs and their supervision are frozen here
        st_nxt.pdo_ms = st_r.pdo_ms;
      end
    endcase

    // Internal and PDO-gap faults send the node to Stopped from the running states
    if ((st_r.state == nmt_node_pkg::ST_PREOP || st_r.state == nmt_node_pkg::ST_OPER)
        && (i_internal_fault || st_r.pdo_fault))
      st_nxt.state = nmt_node_pkg::ST_STOP;

    // Network-management commands
    if (nmt_hit)
    begin
      unique case (i_rx_data0)
        nmt_node_pkg::CMD_OPER:
          if (!i_internal_fault && !st_r.pdo_fault)
          begin
            st_nxt.state  = nmt_node_pkg::ST_OPER;
            st_nxt.pdo_ms = '0;
          end
        nmt_node_pkg::CMD_STOP:
          st_nxt.state = nmt_node_pkg::ST_STOP;
        nmt_node_pkg::CMD_PREOP:
          if (!i_internal_fault && !st_r.pdo_fault)
            st_nxt.state = nmt_node_pkg::ST_PREOP;
        nmt_node_pkg::CMD_RST_NODE, nmt_node_pkg::CMD_RST_COMM:
        begin
          // Like a power cycle, but input synchronisers and ms prescaler keep running, node number and rate keep their values
          st_nxt.state     = nmt_node_pkg::ST_INIT;
          st_nxt.init_busy = 1'b1;
          st_nxt.pend      = '0;
          st_nxt.tx_valid  = 1'b0;
          st_nxt.pdo_fault = 1'b0;
          st_nxt.pdo_ms    = '0;
          st_nxt.err       = '0;
          st_nxt.conflict  = 1'b0;
        end
        default: ;
      endcase
    end

    // Selector conflict; uses the selector being latched so boot shows no false flag
    if (st_nxt.state != nmt_node_pkg::ST_INIT)
      st_nxt.conflict =
        (st_nxt.sel >= nmt_node_pkg::SEL_DIG_FIRST && st_nxt.sel <= nmt_node_pkg::SEL_DIG_LAST
         && !i_line_is_input[st_nxt.sel - nmt_node_pkg::SEL_DIG_FIRST])
        || (st_nxt.sel >= nmt_node_pkg::SEL_VIR_FIRST
            && st_nxt.sel <= nmt_node_pkg::SEL_ENC1_LAST && i_enc1_en)
        || (st_nxt.sel > nmt_node_pkg::SEL_ENC1_LAST
            && st_nxt.sel <= nmt_node_pkg::SEL_ENC2_LAST && i_enc2_en);

    // Heartbeat period and emergency on any change of the fault set
    fault_vec = {st_r.conflict, st_r.pdo_fault, i_internal_fault};
    if (st_nxt.state != nmt_node_pkg::ST_INIT && st_r.state != nmt_node_pkg::ST_INIT)
    begin
      if (ms_tick)
      begin
        st_nxt.hb_cnt = st_r.hb_cnt + 16'h1;
        if (st_r.hb_cnt >= 16'(HB_PERIOD_MS - 1))
        begin
          st_nxt.hb_cnt = '0;
          st_nxt.pend[nmt_node_pkg::P_HB] = 1'b1;
        end
      end
      if (fault_vec != st_r.err)
      begin
        st_nxt.err = fault_vec;
        st_nxt.pend[nmt_node_pkg::P_EMCY] = 1'b1;
      end
    end

    // Outside Operational no PDO may wait or be offered
    if (st_nxt.state != nmt_node_pkg::ST_OPER)
    begin
      st_nxt.pend[nmt_node_pkg::P_TPDO1] = 1'b0;
      st_nxt.pend[nmt_node_pkg::P_TPDO2] = 1'b0;
      if (st_r.tx_type == nmt_node_pkg::MT_TPDO1 || st_r.tx_type == nmt_node_pkg::MT_TPDO2)
        st_nxt.tx_valid = 1'b0;
    end

    // Transmit: hold a frame until taken, then offer the next by priority
    if (st_r.tx_valid && i_tx_ready)
      st_nxt.tx_valid = 1'b0;
    if (!st_r.tx_valid && st_nxt.state != nmt_node_pkg::ST_INIT
        && st_r.state != nmt_node_pkg::ST_INIT)
    begin
      if (st_nxt.pend[nmt_node_pkg::P_BOOT])
      begin
        st_nxt.tx_type = nmt_node_pkg::MT_HB;
        st_nxt.tx_d0   = {1'b0, nmt_node_pkg::HB_BOOT};
        st_nxt.pend[nmt_node_pkg::P_BOOT] = 1'b0;
        st_nxt.tx_valid = 1'b1;
      end
      else if (st_nxt.pend[nmt_node_pkg::P_EMCY])
      begin
        st_nxt.tx_type = nmt_node_pkg::MT_EMCY;
        st_nxt.tx_d0   = (st_nxt.err != '0) ? nmt_node_pkg::ERR_SET
                                            : nmt_node_pkg::ERR_CLEAR;
        st_nxt.pend[nmt_node_pkg::P_EMCY] = 1'b0;
        st_nxt.tx_valid = 1'b1;
      end
      else if (st_nxt.pend[nmt_node_pkg::P_TPDO1])
      begin
        st_nxt.tx_type = nmt_node_pkg::MT_TPDO1;
        st_nxt.tx_d0   = '0;
        st_nxt.pend[nmt_node_pkg::P_TPDO1] = 1'b0;
        st_nxt.tx_valid = 1'b1;
      end
      else if (st_nxt.pend[nmt_node_pkg::P_TPDO2])
      begin
        st_nxt.tx_type = nmt_node_pkg::MT_TPDO2;
        st_nxt.tx_d0   = '0;
        st_nxt.pend[nmt_node_pkg::P_TPDO2] = 1'b0;
        st_nxt.tx_valid = 1'b1;
      end
      else if (st_nxt.pend[nmt_node_pkg::P_HB])
      begin
        st_nxt.tx_type = nmt_node_pkg::MT_HB;
        st_nxt.tx_d0   = {1'b0, code_of(st_nxt.state)};
        st_nxt.pend[nmt_node_pkg::P_HB] = 1'b0;
        st_nxt.tx_valid = 1'b1;
      end
    end
    st_nxt.code = code_of(st_nxt.state);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset state is Initialization with all flags clear except init_busy, which is set
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_r           <= '0;
      st_r.init_busy <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register; frame format is the controller's
  assign o_init_busy               = st_r.init_busy;
  assign o_state_code              = st_r.code;
  assign o_tx_valid                = st_r.tx_valid;
  assign o_tx_type                 = st_r.tx_type;
  assign o_tx_data0                = st_r.tx_d0;
  assign o_pdo_accept              = st_r.pdo_acc;
  assign o_sdo_accept              = st_r.sdo_acc;
  assign o_node_number             = st_r.node;
  assign o_bit_rate                = st_r.rate;
  assign o_pdo_timeout_fault       = st_r.pdo_fault;
  assign o_selector_conflict_fault = st_r.conflict;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_init_silent: assert property (st_r.state == nmt_node_pkg::ST_INIT |-> !o_tx_valid)
    else $error("frame offered during initialization");
  a_boot_then_preop: assert property (
    st_r.state == nmt_node_pkg::ST_INIT && i_startup_done && !i_srst
    |=> st_r.state == nmt_node_pkg::ST_PREOP ##1 o_tx_valid
    && o_tx_type == nmt_node_pkg::MT_HB && o_tx_data0 == {1'b0, nmt_node_pkg::HB_BOOT})
    else $error("boot heartbeat or pre-operational entry missing");
  a_preop_no_pdo: assert property (
    st_r.state == nmt_node_pkg::ST_PREOP && o_tx_valid
    |-> o_tx_type != nmt_node_pkg::MT_TPDO1 && o_tx_type != nmt_node_pkg::MT_TPDO2)
    else $error("transmit PDO in pre-operational");
  a_preop_rx_pdo: assert property (
    st_r.state == nmt_node_pkg::ST_PREOP && rx_pdo |=> !o_pdo_accept)
    else $error("receive PDO taken in pre-operational");
  a_enter_oper: assert property (
    st_r.state == nmt_node_pkg::ST_PREOP && nmt_hit
    && i_rx_data0 == nmt_node_pkg::CMD_OPER && !i_internal_fault && !st_r.pdo_fault
    |=> st_r.state == nmt_node_pkg::ST_OPER)
    else $error("operational command not obeyed");
  a_fault_stops: assert property (
    st_r.state == nmt_node_pkg::ST_OPER && i_internal_fault && !nmt_hit
    |=> st_r.state == nmt_node_pkg::ST_STOP)
    else $error("fault did not stop the node");
  a_stop_no_sdo: assert property (
    st_r.state == nmt_node_pkg::ST_STOP |=> !o_sdo_accept && !o_pdo_accept)
    else $error("message taken while stopped");
  a_reset_init: assert property (
    nmt_hit && (i_rx_data0 == nmt_node_pkg::CMD_RST_NODE
    || i_rx_data0 == nmt_node_pkg::CMD_RST_COMM)
    |=> (st_r.state == nmt_node_pkg::ST_INIT && !o_tx_valid) ##1 !o_tx_valid)
    else $error("reset command did not reinitialise");
  a_pdo_gap: assert property (
    st_r.state == nmt_node_pkg::ST_OPER && i_pdo_timeout_ms != '0
    && st_r.pdo_ms > i_pdo_timeout_ms && !nmt_hit |=> o_pdo_timeout_fault)
    else $error("PDO gap fault missing");
  a_node_held: assert property (
    st_r.state != nmt_node_pkg::ST_INIT && $past(st_r.state) != nmt_node_pkg::ST_INIT
    |-> $stable(o_node_number) && $stable(o_bit_rate))
    else $error("node number or rate changed outside initialization");
  a_hb_top_bit: assert property (
    o_tx_valid && o_tx_type == nmt_node_pkg::MT_HB |-> !o_tx_data0[7])
    else $error("heartbeat top bit set");

  c_oper: cover property (st_r.state == nmt_node_pkg::ST_PREOP
    ##1 st_r.state == nmt_node_pkg::ST_OPER);
  c_pdo_answer: cover property (o_pdo_accept ##[1:4] o_tx_valid
    && o_tx_type == nmt_node_pkg::MT_TPDO1);
  c_gap_stop: cover property ($rose(o_pdo_timeout_fault) ##1 st_r.state == nmt_node_pkg::ST_STOP);
  c_reset: cover property (st_r.state == nmt_node_pkg::ST_STOP
    ##1 st_r.state == nmt_node_pkg::ST_INIT);

endmodule

// [nmt_manager_model.sv]
// Network manager model: sends frames to the node and takes its frames
`timescale 1ns/100ps
module nmt_manager_model (
  input  wire logic       i_clk,      // Bench clock
  input  wire logic       i_slow,     // Stall the frame taker
  input  wire logic       i_tx_valid, // Frame offered by the node
  input  wire logic [3:0] i_tx_type,  // Offered type
  input  wire logic [7:0] i_tx_data0, // Offered first byte
  output logic            o_rx_valid, // Frame strobe
  output logic [3:0]      o_rx_type,  // Frame type
  output logic [6:0]      o_rx_node,  // Identifier node field
  output logic [7:0]      o_rx_data0, // First byte
  output logic [7:0]      o_rx_data1, // Second byte
  output logic            o_tx_ready  // Taker ready
);
  int         cnt [16];
  logic [7:0] last [16];
  logic [1:0] ph = 2'h0;
  logic       rdy;
  initial
  begin
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // A stalling taker accepts one cycle in four, like a busy arbitration loss
  // Count a frame when ready is chosen: the node sees both at the next rising edge
  always @(negedge i_clk)
  begin
    rdy = !i_slow || (ph == 2'h3);
    ph <= ph + 2'h1;
    o_tx_ready <= rdy;
    if (i_tx_valid && rdy)
    begin
      cnt[i_tx_type]++;
      last[i_tx_type] = i_tx_data0;
    end
  end
  // Command byte first, address byte second; lines show garbage when idle
  task automatic send(input logic [3:0] t, input logic [6:0] n, input logic [7:0] a, b);
    @(negedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_type <= t;
    o_rx_node <= n;
    o_rx_data0 <= a;
    o_rx_data1 <= b;
    @(negedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_type <= ~t;
    o_rx_node <= ~n;
    o_rx_data0 <= ~a;
    o_rx_data1 <= ~b;
  endtask
endmodule

// [canopen_nmt_node_control_tb.sv]
// Self-checking bench for the node network-management controller
`timescale 1ns/100ps
module canopen_nmt_node_control_tb;
  logic clk, srst, done, ifault, slow, enc1, enc2, rxv, txr, txv, busy, pacc, sacc, pf, cf;
  logic [15:0] tmo;
  logic [2:0]  rate, brate;
  logic [6:0]  lo, hi, rxn, code, node;
  logic [3:0]  sel, rxt, txt;
  logic [8:0]  dig, lin;
  logic [5:0]  virt;
  logic [7:0]  d0, d1, txd;
  logic [31:0] rs = 32'h6809;
  logic [3:0]  sels [6] = '{4'h3, 4'he, 4'hc, 4'ha, 4'h5, 4'h0};
  int err_total, checks_done, cyc, pn, sn, c0, c1;
  canopen_nmt_node_control #(.CYCLES_PER_MS(10), .HB_PERIOD_MS(20)) canopen_nmt_node_control_i (
    .i_clk(clk), .i_srst(srst), .i_startup_done(done), .i_internal_fault(ifault),
    .i_rx_valid(rxv), .i_rx_type(rxt), .i_rx_node(rxn), .i_rx_data0(d0), .i_rx_data1(d1),
    .i_tx_ready(txr), .i_pdo_timeout_ms(tmo), .i_rate_sel(rate), .i_fallback_node_number(lo),
    .i_alternate_node_number(hi), .i_node_number_selector(sel), .i_dig_in(dig),
    .i_virt_in(virt), .i_line_is_input(lin), .i_enc1_en(enc1), .i_enc2_en(enc2),
    .o_init_busy(busy), .o_state_code(code), .o_tx_valid(txv), .o_tx_type(txt),
    .o_tx_data0(txd), .o_pdo_accept(pacc), .o_sdo_accept(sacc), .o_node_number(node),
    .o_bit_rate(brate), .o_pdo_timeout_fault(pf), .o_selector_conflict_fault(cf));
  nmt_manager_model mgr (.i_clk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_type(txt),
    .i_tx_data0(txd), .o_rx_valid(rxv), .o_rx_type(rxt), .o_rx_node(rxn), .o_rx_data0(d0),
    .o_rx_data1(d1), .o_tx_ready(txr));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counts and hang guard, sampled away from the launching edge
  always @(negedge clk)
  begin
    pn += pacc;
    sn += sacc;
    if (++cyc > 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic nmt(input logic [7:0] c, a, input logic [6:0] e);
    mgr.send(nmt_node_pkg::MT_NMT, 7'h00, c, a);
    tick(3);
    chk("state", code, e);
  endtask
  // Random setup, boot, then the latched values must ignore later edits
  task automatic boot(input logic [3:0] s);
    logic [6:0] en;
    logic       ec;
    rs = xs(rs);
    {virt, dig, rate, hi, lo} = rs;
    rs = xs(rs);
    {enc2, enc1, lin} = rs[10:0];
    sel = s;
    tick(8);
    chk("busy", busy, 1);
    chk("quiet", txv, 0);
    c0 = mgr.cnt[14];
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(4);
    en = (s == 0) ? lo : ((s <= 9 ? dig[s - 1] : virt[s - 10]) ? hi : lo);
    ec = (s >= 1 && s <= 9 && !lin[s - 1]) || (s inside {10, 11} && enc1)
      || (s inside {12, 13} && enc2);
    chk("code", code, 7'h7f);
    chk("node", node, en);
    chk("rate", brate, rate == 3'h7 ? 3'h0 : rate);
    chk("conflict", cf, ec);
    chk("boot hb", 16'(mgr.cnt[14] - c0), 1);
    chk("boot byte", mgr.last[14], 0);
    lo <= ~lo;
    hi <= ~hi;
    rate <= rate + 3'h1;
    tick(3);
    chk("node kept", node, en);
    chk("rate kept", brate, rate - 3'h1 == 3'h7 ? 3'h0 : rate - 3'h1);
  endtask
  initial
  begin
    {srst, done, ifault, slow, tmo} = {1'b1, 19'h0};
    tick(8);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      if (i > 0)
      begin
        nmt(i[0] ? nmt_node_pkg::CMD_RST_NODE : nmt_node_pkg::CMD_RST_COMM, 0, 0);
        chk("busy", busy, 1);
      end
      boot(sels[i]);
      $display("boot test %0d done", i);
    end
    {c0, c1} = {mgr.cnt[3], mgr.cnt[5]};
    mgr.send(nmt_node_pkg::MT_SDO_RX, 7'h00, 8'h40, 8'h00);
    mgr.send(nmt_node_pkg::MT_RPDO1, 7'h00, 8'h11, 8'h22);
    tick(4);
    chk("sdo", sn, 1);
    chk("pdo", pn, 0);
    nmt(nmt_node_pkg::CMD_STOP, {1'b1, node}, 7'h7f);
    nmt(nmt_node_pkg::CMD_OPER, 0, 7'h05);
    slow = 1'b1;
    mgr.send(nmt_node_pkg::MT_RPDO1, 7'h00, 8'h11, 8'h22);
    mgr.send(nmt_node_pkg::MT_RPDO2, 7'h00, 8'h33, 8'h44);
    tick(20);
    chk("pdo", pn, 2);
    chk("tpdo", 16'({mgr.cnt[3] - c0, 4'h0} + mgr.cnt[5] - c1), 16'h11);
    slow = 1'b0;
    nmt(nmt_node_pkg::CMD_STOP, {1'b0, node}, 7'h04);
    mgr.send(nmt_node_pkg::MT_SDO_RX, 7'h00, 8'h40, 8'h00);
    mgr.send(nmt_node_pkg::MT_RPDO1, 7'h00, 8'h11, 8'h22);
    tick(250);
    chk("stop in", 16'(pn + sn), 3);
    chk("hb", mgr.last[14], 8'h04);
    nmt(nmt_node_pkg::CMD_PREOP, 0, 7'h7f);
    nmt(nmt_node_pkg::CMD_OPER, 0, 7'h05);
    ifault <= 1'b1;
    tick(8);
    chk("fault stop", code, 7'h04);
    chk("emcy", mgr.last[1], nmt_node_pkg::ERR_SET);
    ifault <= 1'b0;
    tmo <= 16'h3;
    nmt(nmt_node_pkg::CMD_OPER, 0, 7'h05);
    chk("emcy clr", mgr.last[1], nmt_node_pkg::ERR_CLEAR);
    tick(45);
    chk("gap", {pf, code}, 16'h84);
    nmt(nmt_node_pkg::CMD_RST_COMM, 0, 7'h00);
    chk("gap clr", pf, 0);
    $display("state tests done");
    stop_test();
  end
endmodule
